// *** design/rsr_pkg.sv ***
// package: offsets, field positions and state codes of the radio status readout
package rsr_pkg;
    localparam logic [5:0] ADDR_RADIO_FSM_STATE = 6'h35;
    localparam logic [5:0] ADDR_PIN_LEVEL_STATUS = 6'h38;
    localparam logic [5:0] ADDR_TX_FIFO_FILL_STATUS = 6'h3A;
    localparam int STATE_W = 5;
    localparam int COUNT_W = 7;
    localparam int POS_SECOND_PIN = 2;
    localparam int POS_FIRST_PIN = 0;
    localparam int POS_STARVED = 7;
    localparam int BYTE_MSB = 7;
    localparam int POS_PIN_RSV_LO = 3;
    localparam int POS_PIN_UNUSED = 1;
    localparam logic [2:0] STATE_FILL = 3'h0;
    localparam logic [7:0] READ_RESET = 8'h00;
    localparam logic [4:0] RESERVED_PIN_BITS = 5'h00;

    localparam logic [4:0] CODE_SLEEP = 5'h00;
    localparam logic [4:0] CODE_IDLE = 5'h01;
    localparam logic [4:0] CODE_XTAL_OFF = 5'h02;
    localparam logic [4:0] CODE_OSC_ON_MANUAL_CAL = 5'h03;
    localparam logic [4:0] CODE_REGULATOR_ON_MANUAL_CAL = 5'h04;
    localparam logic [4:0] CODE_MANUAL_CALIBRATION = 5'h05;
    localparam logic [4:0] CODE_OSC_ON = 5'h06;
    localparam logic [4:0] CODE_REGULATOR_ON = 5'h07;
    localparam logic [4:0] CODE_CALIBRATION_BEGIN = 5'h08;
    localparam logic [4:0] CODE_LOOP_BW_BOOST = 5'h09;
    localparam logic [4:0] CODE_SYNTH_LOCK = 5'h0A;
    localparam logic [4:0] CODE_CALIBRATION_FINISH = 5'h0C;
    localparam logic [4:0] CODE_SYNTH_ON_READY = 5'h12;
    localparam logic [4:0] CODE_TX = 5'h13;
    localparam logic [4:0] CODE_TX_END = 5'h14;
    localparam logic [4:0] CODE_FIFO_STARVED = 5'h16;

    // observed signals from the radio core
    typedef struct packed {
        logic [4:0] state_code;
        logic second_output_pin;
        logic first_output_pin;
        logic fifo_starved_flag;
        logic [6:0] fifo_byte_count;
    } rsr_observe_t;
endpackage

// *** design/rsr_status_regs.sv ***
// radio status readout: read-only state, pin level and fifo fill registers
// Summary of operation
// - State codes: sleep 0, idle 1, crystal off 2, ... fifo underflow 0x16.
// - State code in bits 4:0, bits 7:5 zero; reserved codes never reported.
// - Sleep and crystal-off seldom seen: chip select low forces idle first.
// - Bit 2 of pin status is the live, non-inverted second output pin.
// - Bit 0 of pin status is the live, non-inverted first output pin.
// - Pin status bits 7:3 reserved (read zero here), bit 1 reads zero.
// - FIFO status bit 7 is the read-only underflow flag.
// - FIFO status bits 6:0 hold the 7-bit byte count.
`timescale 1ns/10ps
module rsr_status_regs (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // register access from the serial control port
    input wire logic RD_EN,
    input wire logic WR_EN,
    input wire logic [5:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic RD_VALID,
    output logic ADDR_HIT,
    // observed radio core signals, same clock
    input wire logic [4:0] STATE_CODE,
    input wire logic FIFO_STARVED_FLAG,
    input wire logic [6:0] FIFO_BYTE_COUNT,
    // general output pin levels before inversion, from pin domain
    input wire logic SECOND_OUTPUT_PIN,
    input wire logic FIRST_OUTPUT_PIN
);
    // slot indices for the pins and the register select
    localparam int PIN_COUNT = 2;
    localparam int PIN_SECOND = 1;
    localparam int PIN_FIRST = 0;
    localparam int SEL_STATE = 0;
    localparam int SEL_PINS = 1;
    localparam int SEL_FIFO = 2;
    localparam int SEL_COUNT = 3;

    // synchroniser, state and read path
    rsr_pkg::rsr_observe_t obs;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_sync1;
    logic [PIN_COUNT-1:0] pin_sync2;
    logic [4:0] state_seen;
    logic [4:0] next_state_seen;
    logic [SEL_COUNT-1:0] reg_sel;
    logic [7:0] state_image;
    logic [7:0] pin_image;
    logic [7:0] fifo_image;
    logic [7:0] next_rdata;
    logic next_rd_valid;
    logic access;

    // keep only documented codes; reserved ones hold the last good code
    function automatic logic code_is_valid(input logic [4:0] c);
        case (c)
            rsr_pkg::CODE_SLEEP,
            rsr_pkg::CODE_IDLE,
            rsr_pkg::CODE_XTAL_OFF,
            rsr_pkg::CODE_OSC_ON_MANUAL_CAL,
            rsr_pkg::CODE_REGULATOR_ON_MANUAL_CAL,
            rsr_pkg::CODE_MANUAL_CALIBRATION,
            rsr_pkg::CODE_OSC_ON,
            rsr_pkg::CODE_REGULATOR_ON,
            rsr_pkg::CODE_CALIBRATION_BEGIN,
            rsr_pkg::CODE_LOOP_BW_BOOST,
            rsr_pkg::CODE_SYNTH_LOCK,
            rsr_pkg::CODE_CALIBRATION_FINISH,
            rsr_pkg::CODE_SYNTH_ON_READY,
            rsr_pkg::CODE_TX,
            rsr_pkg::CODE_TX_END,
            rsr_pkg::CODE_FIFO_STARVED: code_is_valid = 1'h1;
            default: code_is_valid = 1'h0;
        endcase
    endfunction

    // one-hot register select, shared by the read mux and the hit strobe
    function automatic logic [SEL_COUNT-1:0] decode_sel(input logic [5:0] a);
        decode_sel = '0;
        case (a)
            rsr_pkg::ADDR_RADIO_FSM_STATE: begin
                decode_sel[SEL_STATE] = 1'h1;
            end
            rsr_pkg::ADDR_PIN_LEVEL_STATUS: begin
                decode_sel[SEL_PINS] = 1'h1;
            end
            rsr_pkg::ADDR_TX_FIFO_FILL_STATUS: begin
                decode_sel[SEL_FIFO] = 1'h1;
            end
            default: begin
                decode_sel = '0;
            end
        endcase
    endfunction

    function automatic logic is_mapped(input logic [5:0] a);
        is_mapped = |decode_sel(a);
    endfunction

    // state image: code low, unused bits zero
    function automatic logic [7:0] state_byte(input logic [4:0] code);
        state_byte = rsr_pkg::READ_RESET;
        state_byte[rsr_pkg::BYTE_MSB:rsr_pkg::STATE_W] = rsr_pkg::STATE_FILL;
        state_byte[rsr_pkg::STATE_W-1:0] = code;
    endfunction

    // pin image: live levels, filler and unused bit zero
    function automatic logic [7:0] pin_byte(input logic second, input logic first);
        pin_byte = rsr_pkg::READ_RESET;
        pin_byte[rsr_pkg::BYTE_MSB:rsr_pkg::POS_PIN_RSV_LO] = rsr_pkg::RESERVED_PIN_BITS;
        pin_byte[rsr_pkg::POS_PIN_UNUSED] = 1'h0;
        pin_byte[rsr_pkg::POS_SECOND_PIN] = second;
        pin_byte[rsr_pkg::POS_FIRST_PIN] = first;
    endfunction

    // fifo image: underflow flag above the byte count
    function automatic logic [7:0] fifo_byte(input logic starved, input logic [6:0] count);
        fifo_byte = rsr_pkg::READ_RESET;
        fifo_byte[rsr_pkg::POS_STARVED] = starved;
        fifo_byte[rsr_pkg::COUNT_W-1:0] = count;
    endfunction

    // pin levels come from the pad side; two flops before any logic
    assign pin_raw[PIN_SECOND] = SECOND_OUTPUT_PIN;
    assign pin_raw[PIN_FIRST] = FIRST_OUTPUT_PIN;

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin_sync
        always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
                pin_sync1[i] <= 1'h0;
                pin_sync2[i] <= 1'h0;
            end else begin
                pin_sync1[i] <= pin_raw[i];
                pin_sync2[i] <= pin_sync1[i];
            end
        end
    end

    // reserved codes are never latched, so never read back
    always_comb begin
        next_state_seen = state_seen;
        if (code_is_valid(STATE_CODE)) begin
            next_state_seen = STATE_CODE;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_seen <= rsr_pkg::CODE_IDLE;
        end else begin
            state_seen <= next_state_seen;
        end
    end

    // gather the observed values in one carrier
    always_comb begin
        obs.state_code = state_seen;
        obs.second_output_pin = pin_sync2[PIN_SECOND];
        obs.first_output_pin = pin_sync2[PIN_FIRST];
        obs.fifo_starved_flag = FIFO_STARVED_FLAG;
        obs.fifo_byte_count = FIFO_BYTE_COUNT;
    end

    // register images, rebuilt every cycle
    always_comb begin
        state_image = state_byte(obs.state_code);
    end

    always_comb begin
        pin_image = pin_byte(obs.second_output_pin, obs.first_output_pin);
    end

    always_comb begin
        fifo_image = fifo_byte(obs.fifo_starved_flag, obs.fifo_byte_count);
    end

    assign reg_sel = decode_sel(ADDR);

    // read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = rsr_pkg::READ_RESET;
        if (reg_sel[SEL_STATE]) begin
            next_rdata = state_image;
        end else if (reg_sel[SEL_PINS]) begin
            next_rdata = pin_image;
        end else if (reg_sel[SEL_FIFO]) begin
            next_rdata = fifo_image;
        end else begin
            next_rdata = rsr_pkg::READ_RESET;
        end
    end

    // reads only copy an image out; nothing observed is altered
    assign next_rd_valid = RD_EN;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RD_VALID <= 1'h0;
        end else begin
            RD_VALID <= next_rd_valid;
        end
    end

    // data holds the last read; write data has no sink
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= rsr_pkg::READ_RESET;
        end else if (RD_EN) begin
            RDATA <= next_rdata;
        end
    end

    // address hit strobe for the port front end
    always_comb begin
        access = RD_EN || WR_EN;
        ADDR_HIT = access && is_mapped(ADDR);
    end
endmodule // rsr_status_regs

// *** tb/rsr_status_regs_chk.sv ***
// checker: port-level assertions for the radio status readout
`timescale 1ns/10ps
module rsr_status_regs_chk (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // register access, observed only
    input wire logic RD_EN,
    input wire logic WR_EN,
    input wire logic [5:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic RD_VALID,
    input wire logic ADDR_HIT,
    // observed radio core and pins
    input wire logic [4:0] STATE_CODE,
    input wire logic FIFO_STARVED_FLAG,
    input wire logic [6:0] FIFO_BYTE_COUNT,
    input wire logic SECOND_OUTPUT_PIN,
    input wire logic FIRST_OUTPUT_PIN
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    sequence rd_of(logic [5:0] a);
        RD_EN && ADDR == a;
    endsequence
    sequence wr_only;
        WR_EN && !RD_EN;
    endsequence
    state_code_a: assert property (
        rd_of(6'h35) ##0 $past(RESETN) && !($past(STATE_CODE) inside
        {5'h0B, [5'h0D:5'h11], 5'h15, [5'h17:5'h1F]}) |=> RDATA[4:0] == $past(STATE_CODE, 2))
        else $error("state code not returned");
    no_reserved_a: assert property (
        RD_VALID && $past(ADDR) == 6'h35 |-> RDATA[7:5] == 3'h0 &&
        !(RDATA[4:0] inside {5'h0B, [5'h0D:5'h11], 5'h15, [5'h17:5'h1F]}))
        else $error("bad state byte");
    second_pin_a: assert property (
        rd_of(6'h38) ##0 $past(RESETN, 2) |=> RDATA[2] == $past(SECOND_OUTPUT_PIN, 3))
        else $error("second pin wrong");
    first_pin_a: assert property (
        rd_of(6'h38) ##0 $past(RESETN, 2) |=> RDATA[0] == $past(FIRST_OUTPUT_PIN, 3))
        else $error("first pin wrong");
    pin_unused_a: assert property (
        rd_of(6'h38) |=> RDATA[7:3] == 5'h00 && !RDATA[1])
        else $error("pin status filler set");
    starved_bit_a: assert property (
        rd_of(6'h3A) |=> RDATA[7] == $past(FIFO_STARVED_FLAG))
        else $error("underflow bit wrong");
    fill_count_a: assert property (
        rd_of(6'h3A) |=> RDATA[6:0] == $past(FIFO_BYTE_COUNT))
        else $error("fifo count wrong");
    write_ignored_a: assert property (
        wr_only |=> $stable(RDATA) && !RD_VALID)
        else $error("write had effect");
    read_valid_a: assert property (
        RD_VALID == $past(RD_EN))
        else $error("read valid not one cycle after request");
    addr_hit_a: assert property (
        ADDR_HIT == ((RD_EN || WR_EN) && (ADDR inside {6'h35, 6'h38, 6'h3A})))
        else $error("address hit strobe wrong");
endmodule // rsr_status_regs_chk
bind rsr_status_regs rsr_status_regs_chk u_chk (
    .REF_CLK(REF_CLK),
    .RESETN(RESETN),
    .RD_EN(RD_EN),
    .WR_EN(WR_EN),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .RDATA(RDATA),
    .RD_VALID(RD_VALID),
    .ADDR_HIT(ADDR_HIT),
    .STATE_CODE(STATE_CODE),
    .FIFO_STARVED_FLAG(FIFO_STARVED_FLAG),
    .FIFO_BYTE_COUNT(FIFO_BYTE_COUNT),
    .SECOND_OUTPUT_PIN(SECOND_OUTPUT_PIN),
    .FIRST_OUTPUT_PIN(FIRST_OUTPUT_PIN)
);

// *** tb/rsr_host_model.sv ***
// host side model: issues single-byte register transfers
`timescale 1ns/10ps
module rsr_host_model (
    // clock and read answer
    input wire logic REF_CLK,
    input wire logic RD_VALID,
    input wire logic [7:0] RDATA,
    // register access toward the readout
    output logic RD_EN,
    output logic WR_EN,
    output logic [5:0] ADDR,
    output logic [7:0] WDATA
);
    initial begin
        {RD_EN, WR_EN, ADDR, WDATA} = 16'h003F;
    end
    // pin bits never polled as a lock flag; released address inverted
    task automatic xfer(input logic w, input logic [5:0] a, output logic [8:0] d);
        @(negedge REF_CLK);
        {RD_EN, WR_EN, ADDR, WDATA} = {!w, w, a, 8'hFF};
        @(negedge REF_CLK);
        d = {RD_VALID, RDATA};
        {RD_EN, WR_EN, ADDR} = {2'h0, ~a};
    endtask
endmodule // rsr_host_model

// *** tb/radio_status_readout_tb_top.sv ***
// testbench: directed reads and writes of the radio status readout
`timescale 1ns/10ps
module radio_status_readout_tb_top;
    logic REF_CLK = 0, RESETN = 0, FIFO_STARVED_FLAG = 0, SECOND_OUTPUT_PIN = 0;
    logic FIRST_OUTPUT_PIN = 0, RD_EN, WR_EN, RD_VALID, ADDR_HIT;
    logic [4:0] STATE_CODE = 5'h01;
    logic [6:0] FIFO_BYTE_COUNT = 7'h00;
    logic [5:0] ADDR;
    logic [7:0] WDATA, RDATA;
    int err_count = 0, checked = 0, cycles = 0;
    always #2 REF_CLK = ~REF_CLK;
    rsr_status_regs u_dut (
        .REF_CLK(REF_CLK),
        .RESETN(RESETN),
        .RD_EN(RD_EN),
        .WR_EN(WR_EN),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .RDATA(RDATA),
        .RD_VALID(RD_VALID),
        .ADDR_HIT(ADDR_HIT),
        .STATE_CODE(STATE_CODE),
        .FIFO_STARVED_FLAG(FIFO_STARVED_FLAG),
        .FIFO_BYTE_COUNT(FIFO_BYTE_COUNT),
        .SECOND_OUTPUT_PIN(SECOND_OUTPUT_PIN),
        .FIRST_OUTPUT_PIN(FIRST_OUTPUT_PIN)
    );
    rsr_host_model u_host (
        .REF_CLK(REF_CLK),
        .RD_VALID(RD_VALID),
        .RDATA(RDATA),
        .RD_EN(RD_EN),
        .WR_EN(WR_EN),
        .ADDR(ADDR),
        .WDATA(WDATA)
    );
    task automatic rd(input logic w, input logic [5:0] a, input logic [8:0] exp);
        logic [8:0] got;
        u_host.xfer(w, a, got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic t_state;
        logic [4:0] k = 5'h01;
        for (int c = 0; c < 32; c++) begin
            @(negedge REF_CLK) STATE_CODE = c[4:0];
            if (!(c inside {11, [13:17], 21, [23:31]})) k = c[4:0];
            rd(0, 6'h35, {4'h8, k});
        end
    endtask
    task automatic t_pins;
        for (int p = 0; p < 4; p++) begin
            @(negedge REF_CLK) {SECOND_OUTPUT_PIN, FIRST_OUTPUT_PIN} = p[1:0];
            repeat (3) @(negedge REF_CLK);
            rd(0, 6'h38, {6'h20, p[1], 1'h0, p[0]});
        end
    endtask
    task automatic t_fifo;
        logic [7:0] v[4] = '{8'h00, 8'h7F, 8'h80, 8'hD5};
        foreach (v[i]) begin
            @(negedge REF_CLK) {FIFO_STARVED_FLAG, FIFO_BYTE_COUNT} = v[i];
            rd(0, 6'h3A, {1'h1, v[i]});
        end
    endtask
    task automatic t_ro;
        @(negedge REF_CLK) {FIFO_STARVED_FLAG, FIFO_BYTE_COUNT} = 8'hAB;
        rd(1, 6'h3A, 9'h0D5);
        rd(1, 6'h35, 9'h0D5);
        rd(0, 6'h3B, 9'h100);
        rd(0, 6'h3A, 9'h1AB);
    endtask
    task automatic results;
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge REF_CLK) if (++cycles > 2000) begin
        err_count++;
        results();
    end
    initial begin
        repeat (20) @(negedge REF_CLK);
        RESETN = 1;
        t_state();
        t_pins();
        t_fifo();
        t_ro();
        results();
    end
endmodule // radio_status_readout_tb_top
